// file: cfs_supervisor.sv
// converter fault supervisor: protection, discharge, spread and power good
//
// Functional notes
// R1: spread active: frequency swings plus/minus ten percent, triangular.
// R2: spread only if bit set, forced pwm, no external sync clock.
// R3: discharge enable bit gates discharge; resets to enabled.
// R4: discharge on when enable low, switching bit 0, or fault.
// R5: discharge inactive after power-up until device enabled once.
// R6: supply low lockout stops switching; discharge if enabled.
// R7: supply high lockout stops switching; discharge if enabled.
// R8: after high lockout clears, switching resumes with fresh soft-start.
// R9: high limit turns high side off until current below low limit.
// R10: retry protection only when its bit is 1; resets disabled.
// R11: 32 limited cycles: stop 128 us, soft-start, repeat.
// R12: retry event sets status flag and holds power good low.
// R13: retry flag clears on status read only if overload gone.
// R14: power good rising edge delayed by 40 us deglitch.
// R15: no retry: limit forever; flag after four consecutive limited cycles.
// R16: current limit flag clears on status read only if overload gone.
// R17: standalone drives power good open drain; secondary reads it.
// R18: power good low on lockouts, enable low, soft-start, thermal.
// R19: power good released in window, or blanked during ramp.
// R20: blanking bit ignores window comparator during voltage ramp.
// R21: forced pwm is mode pin OR forced pwm bit.
// R22: asynchronous comparator inputs pass two-stage synchronizer.
// R23: consecutive limit counter clears on any unlimited cycle.
`timescale 1ns/100ps
`include "cfs_params.svh"

module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter int HICCUP_PAUSE_CYC = `CFS_HICCUP_PAUSE_CYC,
  parameter int PG_DEGLITCH_CYC = `CFS_PG_DEGLITCH_CYC,
  parameter int SS_CYC = 1000,
  parameter int SPREAD_STEPS = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic enable_pin_in,
  input wire logic mode_pin_in,
  input wire logic ext_sync_present_in,
  input wire logic secondary_role_in,
  input wire logic ramp_active_in,
  input wire logic cycle_start_in,
  input wire logic current_high_in,
  input wire logic current_low_in,
  input wire cfs_cmp_t cmp_in,
  input wire logic power_good_pin_in,
  output logic switching_out,
  output logic high_side_on_out,
  output logic discharge_out,
  output logic forced_pwm_out,
  output logic spread_active_out,
  output logic signed [7:0] freq_trim_out,
  output logic ccm_allowed_out,
  output logic power_good_pin_out,
  output logic power_good_pin_oe_out
);

  // ****************************************
  // synchronizers
  // ****************************************
  localparam int NS = $bits(cfs_cmp_t) + 2;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  cfs_cmp_t cmp;
  logic cur_hi;
  logic cur_lo;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {cmp_in, current_high_in, current_low_in}; // R22
      sync2 <= sync1;
    end
  end
  assign cmp = cfs_cmp_t'(sync2[NS-1:2]);
  assign cur_hi = sync2[1];
  assign cur_lo = sync2[0];

  // ****************************************
  // registers
  // ****************************************
  cfs_ctl_t ctl;
  logic [7:0] ctl_word;
  logic flag_hiccup;
  logic flag_current_limit_flag;
  logic status_rd;
  logic overload;
  localparam logic [7:0] CTL_RESET = `CFS_CTL_RESET;

  assign status_rd = reg_rd_in && reg_addr_in == `CFS_ADDR_STATUS;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // field by field: struct order is not the register bit map
      ctl.spread_enable_bit <= CTL_RESET[`CFS_CTL_SPREAD];
      ctl.forced_pwm_bit <= CTL_RESET[`CFS_CTL_FPWM];
      ctl.discharge_enable_bit <= CTL_RESET[`CFS_CTL_DISCH]; // R3
      ctl.switching_enable_bit <= CTL_RESET[`CFS_CTL_SWITCHING_ENABLE_BIT];
      ctl.retry_protection_enable_bit <= CTL_RESET[`CFS_CTL_HICCUP]; // R10
      ctl.good_blank_during_ramp <= CTL_RESET[`CFS_CTL_BLANK];
    end else if (reg_wr_in && reg_addr_in == `CFS_ADDR_CONTROL) begin
      ctl.spread_enable_bit <= reg_wdata_in[`CFS_CTL_SPREAD];
      ctl.forced_pwm_bit <= reg_wdata_in[`CFS_CTL_FPWM];
      ctl.discharge_enable_bit <= reg_wdata_in[`CFS_CTL_DISCH];
      ctl.switching_enable_bit <= reg_wdata_in[`CFS_CTL_SWITCHING_ENABLE_BIT];
      ctl.retry_protection_enable_bit <= reg_wdata_in[`CFS_CTL_HICCUP];
      ctl.good_blank_during_ramp <= reg_wdata_in[`CFS_CTL_BLANK];
    end
  end

  // ****************************************
  // control readback
  // ****************************************
  // bits 7:6 are spare and read as zero
  always_comb begin
    ctl_word = 8'h00;
    ctl_word[`CFS_CTL_SPREAD] = ctl.spread_enable_bit;
    ctl_word[`CFS_CTL_FPWM] = ctl.forced_pwm_bit;
    ctl_word[`CFS_CTL_DISCH] = ctl.discharge_enable_bit;
    ctl_word[`CFS_CTL_SWITCHING_ENABLE_BIT] = ctl.switching_enable_bit;
    ctl_word[`CFS_CTL_HICCUP] = ctl.retry_protection_enable_bit;
    ctl_word[`CFS_CTL_BLANK] = ctl.good_blank_during_ramp;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `CFS_ADDR_CONTROL: reg_rdata_out <= ctl_word;
        `CFS_ADDR_STATUS:
          reg_rdata_out <= {6'h00, flag_current_limit_flag, flag_hiccup};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // mode and spread spectrum
  // ****************************************
  logic [7:0] tri_pos;
  logic tri_up;

  assign forced_pwm_out = mode_pin_in | ctl.forced_pwm_bit; // R21
  assign spread_active_out = ctl.spread_enable_bit && forced_pwm_out &&
                             !ext_sync_present_in; // R2

  // triangular trim, full scale meaning plus/minus ten percent
  // steps once per switching cycle, parked at zero while spread is off
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tri_pos <= 8'h00;
      tri_up <= 1'b1;
    end else if (!spread_active_out) begin
      tri_pos <= 8'h00;
      tri_up <= 1'b1;
    end else if (cycle_start_in) begin
      if (tri_up) begin
        tri_pos <= tri_pos + 8'h01; // R1
        if (tri_pos == 8'(SPREAD_STEPS - 1)) begin
          tri_up <= 1'b0;
        end
      end else begin
        tri_pos <= tri_pos - 8'h01; // R1
        if (tri_pos == 8'(1 - SPREAD_STEPS)) begin
          tri_up <= 1'b1;
        end
      end
    end
  end
  assign freq_trim_out = tri_pos;

  // ****************************************
  // current limiting
  // ****************************************
  logic limiting;
  logic cycle_limited;
  logic [5:0] lim_count;
  logic hiccup_trip;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      limiting <= 1'b0;
    end else if (cur_hi) begin
      limiting <= 1'b1; // R9
    end else if (cur_lo) begin
      limiting <= 1'b0; // R9
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cycle_limited <= 1'b0;
      lim_count <= 6'h00;
    end else if (!switching_out) begin
      cycle_limited <= 1'b0;
      lim_count <= 6'h00;
    end else if (cycle_start_in) begin
      cycle_limited <= cur_hi;
      if (!(cycle_limited || cur_hi)) begin
        lim_count <= 6'h00; // R23
      end else if (lim_count != 6'h3F) begin
        lim_count <= lim_count + 6'h01;
      end
    end else if (cur_hi) begin
      cycle_limited <= 1'b1;
    end
  end

  // overload stays up until a clean cycle or a stop of switching has cleared the count
  assign overload = lim_count != 6'h00 || cur_hi;
  assign hiccup_trip = ctl.retry_protection_enable_bit &&
                       lim_count >= 6'(`CFS_HICCUP_CYCLES); // R11
  assign high_side_on_out = switching_out && !limiting; // R9

  // ****************************************
  // switching sequencer
  // ****************************************
  cfs_state_t state;
  logic [31:0] timer;
  logic run_ok;
  logic was_enabled;

  assign run_ok = enable_pin_in && ctl.switching_enable_bit &&
                  !cmp.supply_low && !cmp.supply_high &&
                  !cmp.thermal_shutdown; // R6 R7

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= CFS_OFF;
      timer <= '0;
    end else begin
      unique case (state)
        CFS_OFF: begin
          timer <= '0;
          if (run_ok) begin
            state <= CFS_SOFTSTART; // R8
          end
        end
        CFS_SOFTSTART: begin
          timer <= timer + 32'd1;
          if (!run_ok) begin
            state <= CFS_OFF;
          end else if (hiccup_trip) begin
            state <= CFS_PAUSE;
            timer <= '0;
          end else if (timer >= 32'(SS_CYC - 1)) begin
            state <= CFS_RUN;
          end
        end
        CFS_RUN: begin
          timer <= '0;
          if (!run_ok) begin
            state <= CFS_OFF;
          end else if (hiccup_trip) begin
            state <= CFS_PAUSE; // R11
          end
        end
        CFS_PAUSE: begin
          timer <= timer + 32'd1;
          if (timer >= 32'(HICCUP_PAUSE_CYC - 1)) begin
            state <= CFS_OFF; // R11
            timer <= '0;
          end
        end
      endcase
    end
  end

  // a pause always ends in OFF, so a restart is a fresh soft-start
  assign switching_out = state == CFS_SOFTSTART || state == CFS_RUN;

  // ****************************************
  // output discharge
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      was_enabled <= 1'b0;
    end else if (switching_out) begin
      was_enabled <= 1'b1; // R5
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      discharge_out <= 1'b0;
    end else begin
      discharge_out <= was_enabled && ctl.discharge_enable_bit &&
                       (!enable_pin_in || !ctl.switching_enable_bit ||
                        cmp.thermal_shutdown || cmp.supply_low ||
                        cmp.supply_high); // R3 R4 R5 R6 R7
    end
  end

  // ****************************************
  // status flags, set wins over read clear
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_hiccup <= 1'b0;
    end else if (hiccup_trip && switching_out) begin
      flag_hiccup <= 1'b1; // R12
    end else if (status_rd && !overload) begin
      flag_hiccup <= 1'b0; // R13
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_current_limit_flag <= 1'b0;
    end else if (!ctl.retry_protection_enable_bit &&
                 lim_count >= 6'(`CFS_CURRENT_LIMIT_FLAG_CYCLES)) begin
      flag_current_limit_flag <= 1'b1; // R15
    end else if (status_rd && !overload) begin
      flag_current_limit_flag <= 1'b0; // R16
    end
  end

  // ****************************************
  // power good
  // ****************************************
  logic pg_raw;
  logic pg_good;
  logic [31:0] pg_count;

  // pull low as long as a hiccup pause or soft-start runs
  assign pg_raw = cmp.supply_above_2v && state == CFS_RUN &&
                  enable_pin_in && !cmp.supply_low && !cmp.supply_high &&
                  !cmp.thermal_shutdown &&
                  (cmp.window_ok ||
                   (ctl.good_blank_during_ramp && ramp_active_in));
                  // R18 R19 R20 R12

  // only the rising edge is delayed, a fall is immediate
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pg_count <= '0;
      pg_good <= 1'b0;
    end else if (!pg_raw) begin
      pg_count <= '0;
      pg_good <= 1'b0;
    end else if (pg_count >= 32'(PG_DEGLITCH_CYC - 1)) begin
      pg_good <= 1'b1; // R14
    end else begin
      pg_count <= pg_count + 32'd1; // R14
    end
  end

  // secondary: holds the shared line low until own start-up is done
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_good_pin_oe_out <= 1'b1;
      ccm_allowed_out <= 1'b0;
    end else if (secondary_role_in) begin
      power_good_pin_oe_out <= state != CFS_RUN; // R17
      ccm_allowed_out <= state == CFS_RUN && power_good_pin_in; // R17
    end else begin
      power_good_pin_oe_out <= !pg_good; // R17
      ccm_allowed_out <= state == CFS_RUN;
    end
  end
  assign power_good_pin_out = 1'b0;

endmodule

// file: cfs_params.svh
// timing counts, reset values and register layout of the fault supervisor
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

`define CFS_CLK_MHZ 50
`define CFS_HICCUP_PAUSE_US 128
`define CFS_HICCUP_PAUSE_CYC (`CFS_HICCUP_PAUSE_US * `CFS_CLK_MHZ)
`define CFS_PG_DEGLITCH_US 40
`define CFS_PG_DEGLITCH_CYC (`CFS_PG_DEGLITCH_US * `CFS_CLK_MHZ)
`define CFS_HICCUP_CYCLES 32
`define CFS_CURRENT_LIMIT_FLAG_CYCLES 4

`define CFS_ADDR_CONTROL 4'h0
`define CFS_ADDR_STATUS 4'h1

`define CFS_CTL_SPREAD 0
`define CFS_CTL_FPWM 1
`define CFS_CTL_DISCH 2
`define CFS_CTL_SWITCHING_ENABLE_BIT 3
`define CFS_CTL_HICCUP 4
`define CFS_CTL_BLANK 5
`define CFS_CTL_RESET 8'h0C

`define CFS_ST_HICCUP 0
`define CFS_ST_CURRENT_LIMIT_FLAG 1

`endif

// file: cfs_pkg.sv
// types of the converter fault supervisor
package cfs_pkg;
  typedef struct packed {
    logic spread_enable_bit;
    logic forced_pwm_bit;
    logic discharge_enable_bit;
    logic switching_enable_bit;
    logic retry_protection_enable_bit;
    logic good_blank_during_ramp;
  } cfs_ctl_t;

  typedef struct packed {
    logic current_limit;
    logic supply_low;
    logic supply_high;
    logic supply_above_2v;
    logic thermal_shutdown;
    logic window_ok;
  } cfs_cmp_t;

  typedef enum logic [1:0] {
    CFS_OFF,
    CFS_SOFTSTART,
    CFS_RUN,
    CFS_PAUSE
  } cfs_state_t;
endpackage

// file: cfs_properties.sv
// port-level property checker of the converter fault supervisor
`timescale 1ns/100ps
module cfs_properties
  import cfs_pkg::*;
#(
  parameter int PG_DEGLITCH_CYC = 2000
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_pin_in,
  input wire logic ext_sync_present_in,
  input wire logic secondary_role_in,
  input wire logic ramp_active_in,
  input wire logic current_high_in,
  input wire cfs_cmp_t cmp_in,
  input wire logic switching_out,
  input wire logic high_side_on_out,
  input wire logic discharge_out,
  input wire logic forced_pwm_out,
  input wire logic spread_active_out,
  input wire logic signed [7:0] freq_trim_out,
  input wire logic power_good_pin_out,
  input wire logic power_good_pin_oe_out
);
  // ****
  // helper state
  // ****
  int good_run;
  logic was_en;
  logic good_now;
  // raw inputs allow power good; counted ahead of the synchroniser
  assign good_now = enable_pin_in && cmp_in.supply_above_2v &&
                    !cmp_in.supply_low && !cmp_in.supply_high &&
                    !cmp_in.thermal_shutdown &&
                    (cmp_in.window_ok || ramp_active_in);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      good_run <= 0;
      was_en <= 1'b0;
    end else begin
      good_run <= good_now ? good_run + 1 : 0;
      was_en <= was_en | enable_pin_in;
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // causes held past the two-stage input synchroniser
  sequence s_en_low; !enable_pin_in [*4]; endsequence
  sequence s_hot; cmp_in.thermal_shutdown [*4]; endsequence
  sequence s_low; cmp_in.supply_low [*4]; endsequence
  a_pg_en_low: assert property (s_en_low |=> power_good_pin_oe_out)
    else $error("pg released while disabled");
  a_pg_hot: assert property (s_hot |=> power_good_pin_oe_out)
    else $error("pg released in thermal shutdown");
  a_low_stop: assert property (s_low |=> !switching_out)
    else $error("switching in supply low lockout");
  a_pin_low: assert property (power_good_pin_out == 1'b0)
    else $error("pg pin driven high");
  a_spread_gate: assert property (spread_active_out |-> forced_pwm_out)
    else $error("spread without forced pwm");
  a_sync_stops: assert property (
    ext_sync_present_in [*3] |-> !spread_active_out)
    else $error("spread with external sync");
  a_trim_span: assert property (
    freq_trim_out <= 8'sd16 && freq_trim_out >= -8'sd16)
    else $error("trim beyond ten percent");
  a_hs_limit: assert property (current_high_in [*4] |-> !high_side_on_out)
    else $error("high side on above limit");
  a_dis_first: assert property (discharge_out |-> was_en)
    else $error("discharge before first enable");
  a_pg_deglitch: assert property (
    $fell(power_good_pin_oe_out) && !secondary_role_in
      |-> good_run >= PG_DEGLITCH_CYC)
    else $error("pg released before deglitch time");
endmodule

// file: cfs_host_model.sv
// host side of the shared power-good line, with its pull-up
`timescale 1ns/100ps
module cfs_host_model (
  input wire logic pg_oe_in,
  input wire logic pg_drive_in,
  input wire logic peer_low_in,
  output logic pg_line_out
);
  // open drain: any party pulling low wins, else the pull-up
  assign pg_line_out = (pg_oe_in && !pg_drive_in) || peer_low_in ? 1'b0
                                                                : 1'b1;
endmodule

// file: cfs_supervisor_tb.sv
// self-checking bench of the converter fault supervisor
`timescale 1ns/100ps
module cfs_supervisor_tb;
  import cfs_pkg::*;
  localparam int SS = 10;
  localparam int DG = 10;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] a = 4'h0;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0, re = 1'b0, en = 1'b0, mode = 1'b0, sync = 1'b0;
  logic sec = 1'b0, ramp = 1'b0, cs = 1'b0, chi = 1'b0, clo = 1'b1;
  logic peer = 1'b0;
  logic [5:0] cmp = 6'h05;
  logic [7:0] rdata;
  logic sw, hs, dis, fp, spr, ccm, pgo, pgoe, line;
  logic signed [7:0] trim;
  int err_total = 0, samples_checked = 0, cycles = 0;
  // spread, fpwm bit, mode, sync, expected fpwm, expected spread
  logic [5:0] rows [8] = '{6'h00, 6'h20, 6'h33, 6'h2B, 6'h36, 6'h12,
                           6'h0A, 6'h2E};
  logic [5:0] lk [3] = '{6'h10, 6'h08, 6'h02};
  cfs_supervisor #(.HICCUP_PAUSE_CYC(20), .PG_DEGLITCH_CYC(DG),
    .SS_CYC(SS)) u_cfs_supervisor (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(a), .reg_wdata_in(wd),
    .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdata),
    .enable_pin_in(en), .mode_pin_in(mode), .ext_sync_present_in(sync),
    .secondary_role_in(sec), .ramp_active_in(ramp), .cycle_start_in(cs),
    .current_high_in(chi), .current_low_in(clo),
    .cmp_in(cfs_cmp_t'(cmp)), .power_good_pin_in(line),
    .switching_out(sw), .high_side_on_out(hs), .discharge_out(dis),
    .forced_pwm_out(fp), .spread_active_out(spr), .freq_trim_out(trim),
    .ccm_allowed_out(ccm), .power_good_pin_out(pgo),
    .power_good_pin_oe_out(pgoe));
  cfs_host_model u_cfs_host_model (.pg_oe_in(pgoe), .pg_drive_in(pgo),
    .peer_low_in(peer), .pg_line_out(line));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ck1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    a <= ad;
    wd <= v;
    we <= 1'b1;
    wt(1);
    we <= 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] m,
                    input logic [7:0] exp);
    a <= ad;
    re <= 1'b1;
    wt(1);
    re <= 1'b0;
    #1;
    chk(rdata & m, exp);
    wt(1);
  endtask
  // one switching cycle is four clocks
  task automatic cyc(input int n);
    repeat (n) begin
      cs <= 1'b1;
      wt(1);
      cs <= 1'b0;
      wt(3);
    end
  endtask
  task automatic load(input logic h);
    chi <= h;
    clo <= !h;
    wt(4);
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // stimulus
  // ****
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    wt(2);
    ck1(pgoe, 1'b1);
    wt(1);
    reset_n_in <= 1'b1;
    rd(4'h0, 8'hFF, 8'h0C);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'hFF, 8'h00);
    rd(4'h0, 8'hFF, 8'h0C);
    ck1(dis, 1'b0);
    en <= 1'b1;
    wt(SS + 5);
    ck1(pgoe, 1'b1);
    wt(30);
    ck1(pgoe, 1'b0);
    foreach (rows[i]) begin
      wr(4'h0, 8'h0C | {6'h00, rows[i][4], rows[i][5]});
      mode <= rows[i][3];
      sync <= rows[i][2];
      wt(4);
      chk({6'h00, fp, spr}, {6'h00, rows[i][1:0]});
    end
    mode <= 1'b0;
    sync <= 1'b0;
    wr(4'h0, 8'h0F);
    cyc(16);
    chk(trim, 8'h10);
    cyc(32);
    chk(trim, 8'hF0);
    cyc(1);
    chk(trim, 8'hF1);
    cmp <= 6'h04;
    wr(4'h0, 8'h0C);
    wt(5);
    ck1(pgoe, 1'b1);
    ramp <= 1'b1;
    wr(4'h0, 8'h2C);
    wt(DG + 8);
    ck1(pgoe, 1'b0);
    ramp <= 1'b0;
    wt(5);
    ck1(pgoe, 1'b1);
    cmp <= 6'h05;
    wr(4'h0, 8'h0C);
    en <= 1'b0;
    wt(5);
    ck1(dis, 1'b1);
    en <= 1'b1;
    wr(4'h0, 8'h04);
    wt(5);
    ck1(dis, 1'b1);
    wr(4'h0, 8'h00);
    wt(5);
    ck1(dis, 1'b0);
    wr(4'h0, 8'h0C);
    wt(40);
    foreach (lk[k]) begin
      cmp <= 6'h05 | lk[k];
      wt(6);
      ck1(sw, 1'b0);
      ck1(dis, 1'b1);
      cmp <= 6'h05;
      wt(SS + 4);
      ck1(pgoe, 1'b1);
      wt(30);
      ck1(sw, 1'b1);
    end
    load(1'b1);
    ck1(hs, 1'b0);
    cyc(2);
    load(1'b0);
    ck1(hs, 1'b1);
    cyc(2);
    load(1'b1);
    cyc(3);
    rd(4'h1, 8'hFF, 8'h00);
    cyc(1);
    ck1(sw, 1'b1);
    rd(4'h1, 8'hFF, 8'h02);
    rd(4'h1, 8'hFF, 8'h02);
    load(1'b0);
    cyc(2);
    rd(4'h1, 8'hFF, 8'h02);
    rd(4'h1, 8'hFF, 8'h00);
    wr(4'h0, 8'h1C);
    load(1'b1);
    cyc(31);
    ck1(sw, 1'b1);
    cyc(1);
    ck1(sw, 1'b0);
    wt(1);
    ck1(pgoe, 1'b1);
    rd(4'h1, 8'h01, 8'h01);
    rd(4'h1, 8'h01, 8'h01);
    load(1'b0);
    wt(30);
    cyc(2);
    rd(4'h1, 8'h01, 8'h01);
    rd(4'h1, 8'h01, 8'h00);
    wt(SS + DG + 20);
    ck1(pgoe, 1'b0);
    sec <= 1'b1;
    peer <= 1'b1;
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    wt(SS + DG + 30);
    ck1(ccm, 1'b0);
    peer <= 1'b0;
    wt(6);
    ck1(ccm, 1'b1);
    finish_test();
  end
endmodule
bind cfs_supervisor cfs_properties
  #(.PG_DEGLITCH_CYC(PG_DEGLITCH_CYC)) u_cfs_properties (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .enable_pin_in(enable_pin_in),
  .ext_sync_present_in(ext_sync_present_in),
  .secondary_role_in(secondary_role_in),
  .ramp_active_in(ramp_active_in),
  .current_high_in(current_high_in),
  .cmp_in(cmp_in),
  .switching_out(switching_out),
  .high_side_on_out(high_side_on_out),
  .discharge_out(discharge_out),
  .forced_pwm_out(forced_pwm_out),
  .spread_active_out(spread_active_out),
  .freq_trim_out(freq_trim_out),
  .power_good_pin_out(power_good_pin_out),
  .power_good_pin_oe_out(power_good_pin_oe_out));
